// ### common/ldd_pkg.sv
/*
 * Shared constants for the eight-digit LED decoder host port: control
 * word layout, reset value, scan timing and the digit scan order.
 * Assumes a single 100 MHz clock drives every user of this package.
 */
package ldd_pkg;

    // ------------------------------------------------------------
    // Control word layout
    // ------------------------------------------------------------
    localparam int CW_ADDR_LSB = 0;
    localparam int CW_ADDR_W = 3;
    localparam int CW_BANK_BIT = 3;
    localparam int CW_RUN_BIT = 4;
    localparam int CW_DECODE_BIT = 5;
    localparam int CW_HEX_BIT = 6;
    localparam int CW_FOLLOWS_BIT = 7;
    // Zero means shut down: nothing lights before software asks for it
    localparam logic [7:0] CW_RESET = 8'h00;

    // ------------------------------------------------------------
    // Data byte layout
    // ------------------------------------------------------------
    localparam int DB_POINT_BIT = 7;
    localparam int NUM_DIGITS = 8;
    localparam int NUM_BANKS = 2;

    // ------------------------------------------------------------
    // Scan timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 10;
    localparam int US_NS = 1000;
    localparam int CYC_PER_US = US_NS / CLK_PERIOD_NS;
    localparam int DIGIT_PERIOD_US = 320;
    localparam int BLANK_US = 10;

    typedef enum logic {
        PH_BLANK = 1'b0,
        PH_ON = 1'b1
    } ldd_phase_t;

    // Scan slot to digit index (digit n is index n-1): 2,5,1,7,8,6,4,3
    function automatic logic [2:0] ldd_scan_digit(input logic [2:0] slot);
        logic [2:0] idx;
        idx = 3'h0;
        case (slot)
            3'h0: idx = 3'h1;
            3'h1: idx = 3'h4;
            3'h2: idx = 3'h0;
            3'h3: idx = 3'h6;
            3'h4: idx = 3'h7;
            3'h5: idx = 3'h5;
            3'h6: idx = 3'h3;
            default: idx = 3'h2;
        endcase
        return idx;
    endfunction

endpackage

// ### common/ldd_seg_if.sv
/*
 * Carrier between the scan logic and the character decoder.
 * Assumes the decoder is purely combinational.
 */
`timescale 1ns/1ns
`default_nettype none
interface ldd_seg_if;
    logic [3:0] code;
    logic hex_sel;
    logic [6:0] seg;

    modport decoder (input code, input hex_sel, output seg);
    modport user (output code, output hex_sel, input seg);
endinterface
`default_nettype wire

// ### rtl/ldd_char_decoder.sv
/*
 * Four-bit character decoder: hexadecimal or extended BCD set.
 * Output seg is {a,b,c,d,e,f,g}, one meaning lit.
 * Assumes the user registers the result.
 */
`timescale 1ns/1ns
`default_nettype none
module ldd_char_decoder (
    ldd_seg_if.decoder dec
);
    import ldd_pkg::*;

    always_comb begin
        dec.seg = 7'h00;
        case (dec.code)
            4'h0: dec.seg = 7'h7e;
            4'h1: dec.seg = 7'h30;
            4'h2: dec.seg = 7'h6d;
            4'h3: dec.seg = 7'h79;
            4'h4: dec.seg = 7'h33;
            4'h5: dec.seg = 7'h5b;
            4'h6: dec.seg = 7'h5f;
            4'h7: dec.seg = 7'h70;
            4'h8: dec.seg = 7'h7f;
            4'h9: dec.seg = 7'h7b;
            4'ha: dec.seg = dec.hex_sel ? 7'h77 : 7'h01;
            4'hb: dec.seg = dec.hex_sel ? 7'h1f : 7'h4f;
            4'hc: dec.seg = dec.hex_sel ? 7'h4e : 7'h37;
            4'hd: dec.seg = dec.hex_sel ? 7'h3d : 7'h0e;
            4'he: dec.seg = dec.hex_sel ? 7'h4f : 7'h67;
            default: dec.seg = dec.hex_sel ? 7'h47 : 7'h00;
        endcase
    end

endmodule
`default_nettype wire

// ### rtl/ldd_host_port.sv
/*
 * Eight-digit LED decoder: write-only host port, two-bank display
 * memory, entry sequencing and the multiplex scan with blanking.
 * Assumes the host strobe and bus come straight from pins, so each
 * passes a three-stage synchroniser before use.
 */
`timescale 1ns/1ns
`default_nettype none

// How it works
// - Control-only write; bank picks displayed digits
// - Follows flag set blanks, starts sequential entry
// - Eight writes fill digits one to eight
// - After eighth, unblank and ignore further writes
// - Sequence uses preceding word's format and bank
// - Single-digit word carries three-bit digit address
// - Next memory write stores byte at addressed digit
// - Per-digit decode flag; one global hex choice
// - Two nibble banks; raw bytes ignore bank
// - Decimal point shared by both banks
// - Decoded: code bits 0-3, point bit 7
// - Hex and extended-BCD character sets
// - Raw bits map directly onto segments
// - Raw one lights; point lit on zero
// - Shutdown stops scan, drivers all off
// - Writes accepted and data kept while shut down
// - FF extended-BCD or 80 raw shows blank
// - Scan order 2,5,1,7,8,6,4,3 near 390 Hz
// - Blanking gap between successive digits
module ldd_host_port #(
    parameter int unsigned DIGIT_PERIOD_US = ldd_pkg::DIGIT_PERIOD_US,
    parameter int unsigned BLANK_US = ldd_pkg::BLANK_US,
    parameter int unsigned CYC_PER_US = ldd_pkg::CYC_PER_US
) (
    input wire logic ref_clk_in,
    input wire logic rst_in,
    input wire logic write_n_in,
    input wire logic reg_select_in,
    input wire logic [7:0] host_write_bus_in,
    output logic [7:0] digit_drive_out,
    output logic [6:0] segment_out,
    output logic decimal_point_segment_out
);
    import ldd_pkg::*;

    if (BLANK_US < 1 || DIGIT_PERIOD_US <= BLANK_US ||
        DIGIT_PERIOD_US - BLANK_US > 511 || CYC_PER_US < 1 ||
        CYC_PER_US > 255) begin : g_bad_params
        $error("ldd_host_port: timing parameters out of range");
    end

    localparam logic [8:0] ON_LAST = 9'(DIGIT_PERIOD_US - BLANK_US - 1);
    localparam logic [8:0] BLANK_LAST = 9'(BLANK_US - 1);
    localparam logic [7:0] TICK_LAST = 8'(CYC_PER_US - 1);

    // ------------------------------------------------------------
    // Pin synchronisers: {strobe, select, data}
    // ------------------------------------------------------------
    logic [9:0] pin_s1_q;
    logic [9:0] pin_s2_q;
    logic [9:0] pin_s3_q;
    logic [9:0] pin_q;
    logic wr_prev_q;
    logic hold_sel_q;
    logic [7:0] hold_data_q;
    logic commit;
    logic ctrl_wr;
    logic ram_wr;

    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            pin_s1_q <= 10'h200;
            pin_s2_q <= 10'h200;
            pin_s3_q <= 10'h200;
            pin_q <= 10'h200;
        end else begin
            pin_s1_q <= {write_n_in, reg_select_in, host_write_bus_in};
            pin_s2_q <= pin_s1_q;
            pin_s3_q <= pin_s2_q;
            // A bit moves only once the last two stages agree
            pin_q <= (pin_s2_q & pin_s3_q) | (pin_q & (pin_s2_q ^ pin_s3_q));
        end
    end

    // Bus hold time is zero, so the byte is kept while the strobe is
    // still low and used at the strobe's rising edge.
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            wr_prev_q <= 1'b1;
            hold_sel_q <= 1'b0;
            hold_data_q <= 8'h00;
        end else begin
            wr_prev_q <= pin_q[9];
            if (!pin_q[9]) begin
                hold_sel_q <= pin_q[8];
                hold_data_q <= pin_q[7:0];
            end
        end
    end

    assign commit = pin_q[9] && !wr_prev_q;
    assign ctrl_wr = commit && hold_sel_q;
    assign ram_wr = commit && !hold_sel_q;

    // ------------------------------------------------------------
    // Control word and entry sequencing
    // ------------------------------------------------------------
    logic [7:0] ctrl_q;
    logic seq_active_q;
    logic locked_q;
    logic [2:0] seq_cnt_q;
    logic ram_we;
    logic [2:0] wr_addr;
    logic cw_decode;
    logic cw_hex;
    logic cw_run;
    logic cw_bank;

    assign cw_decode = ctrl_q[CW_DECODE_BIT];
    assign cw_hex = ctrl_q[CW_HEX_BIT];
    assign cw_run = ctrl_q[CW_RUN_BIT];
    assign cw_bank = ctrl_q[CW_BANK_BIT];

    // Writes are taken in shutdown too; only the scan stops
    assign ram_we = ram_wr && !locked_q;
    assign wr_addr = seq_active_q ? seq_cnt_q
        : ctrl_q[CW_ADDR_LSB +: CW_ADDR_W];

    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            ctrl_q <= CW_RESET;
        end else if (ctrl_wr) begin
            ctrl_q <= hold_data_q;
        end
    end

    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            seq_active_q <= 1'b0;
            locked_q <= 1'b0;
            seq_cnt_q <= 3'h0;
        end else if (ctrl_wr) begin
            seq_active_q <= hold_data_q[CW_FOLLOWS_BIT];
            locked_q <= 1'b0;
            seq_cnt_q <= 3'h0;
        end else if (ram_we && seq_active_q) begin
            seq_cnt_q <= seq_cnt_q + 3'h1;
            if (seq_cnt_q == 3'h7) begin
                seq_active_q <= 1'b0;
                locked_q <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // Display memory
    // ------------------------------------------------------------
    // Nibble banks; a raw byte keeps its low nibble in bank 0 and its
    // bits 6..4 in raw_hi, so a raw digit never depends on the bank.
    logic [3:0] nib_q [NUM_BANKS][NUM_DIGITS];
    logic [2:0] raw_hi_q [NUM_DIGITS];
    logic [NUM_DIGITS-1:0] point_q;
    logic [NUM_DIGITS-1:0] decoded_q;

    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            for (int i = 0; i < NUM_DIGITS; i++) begin
                nib_q[0][i] <= 4'h0;
                nib_q[1][i] <= 4'h0;
                raw_hi_q[i] <= 3'h0;
            end
        end else if (ram_we) begin
            if (cw_decode) begin
                nib_q[cw_bank][wr_addr] <=
                    hold_data_q[3:0];
            end else begin
                nib_q[0][wr_addr] <= hold_data_q[3:0];
                raw_hi_q[wr_addr] <= hold_data_q[6:4];
            end
        end
    end

    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            point_q <= 8'hff;
            decoded_q <= 8'h00;
        end else if (ram_we) begin
            point_q[wr_addr] <= hold_data_q[DB_POINT_BIT];
            decoded_q[wr_addr] <= cw_decode;
        end
    end

    // ------------------------------------------------------------
    // Scan timing: 1 us enable, then blank and on phases
    // ------------------------------------------------------------
    logic [7:0] div_q;
    logic us_tick;
    ldd_phase_t phase_q;
    logic [8:0] time_q;
    logic [2:0] slot_q;
    logic shut;

    assign shut = !cw_run;
    assign us_tick = (div_q == TICK_LAST);

    // Stopping the divider stands in for stopping the oscillator
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            div_q <= 8'h00;
        end else if (shut) begin
            div_q <= 8'h00;
        end else begin
            div_q <= us_tick ? 8'h00 : div_q + 8'h01;
        end
    end

    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            phase_q <= PH_BLANK;
            time_q <= 9'h000;
            slot_q <= 3'h0;
        end else if (us_tick && !shut) begin
            case (phase_q)
                PH_BLANK: begin
                    if (time_q == BLANK_LAST) begin
                        phase_q <= PH_ON;
                        time_q <= 9'h000;
                    end else begin
                        time_q <= time_q + 9'h001;
                    end
                end
                default: begin
                    if (time_q == ON_LAST) begin
                        phase_q <= PH_BLANK;
                        time_q <= 9'h000;
                        slot_q <= slot_q + 3'h1;
                    end else begin
                        time_q <= time_q + 9'h001;
                    end
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Segment source and output drivers
    // ------------------------------------------------------------
    ldd_seg_if seg_bus ();
    logic [2:0] cur_digit;
    logic [6:0] raw_seg;
    logic [7:0] raw_byte;
    logic lit_ok;

    ldd_char_decoder u_decoder (
        .dec(seg_bus.decoder)
    );

    assign cur_digit = ldd_scan_digit(slot_q);
    assign seg_bus.code = nib_q[cw_bank][cur_digit];
    assign seg_bus.hex_sel = cw_hex;
    assign raw_byte = {point_q[cur_digit], raw_hi_q[cur_digit],
        nib_q[0][cur_digit]};
    // Raw bits 6..0 are a,b,c,e,g,f,d; output order is a..g
    assign raw_seg = {raw_byte[6], raw_byte[5], raw_byte[4], raw_byte[0],
        raw_byte[3], raw_byte[1], raw_byte[2]};
    assign lit_ok = !shut && !seq_active_q && (phase_q == PH_ON);

    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            digit_drive_out <= 8'h00;
            segment_out <= 7'h00;
            decimal_point_segment_out <= 1'b0;
        end else if (!lit_ok) begin
            digit_drive_out <= 8'h00;
            segment_out <= 7'h00;
            decimal_point_segment_out <= 1'b0;
        end else begin
            digit_drive_out <= 8'h01 << cur_digit;
            segment_out <= decoded_q[cur_digit] ? seg_bus.seg
                : raw_seg;
            decimal_point_segment_out <= !point_q[cur_digit];
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (rst_in);

    sequence s_follows_ctrl;
        ctrl_wr && hold_data_q[CW_FOLLOWS_BIT];
    endsequence

    sequence s_last_seq_write;
        ram_we && seq_active_q && (seq_cnt_q == 3'h7);
    endsequence

    seq_start_a: assert property (s_follows_ctrl
        |=> seq_active_q && seq_cnt_q == 3'h0)
        else $error("sequential entry did not restart at digit one");

    seq_advance_a: assert property (ram_we && seq_active_q
        && seq_cnt_q != 3'h7
        |=> seq_active_q && seq_cnt_q == $past(seq_cnt_q) + 3'h1)
        else $error("sequential counter did not advance by one");

    seq_end_lock_a: assert property (s_last_seq_write
        |=> !seq_active_q && locked_q ##1 !ram_we [*2])
        else $error("eighth write did not end and lock the sequence");

    seq_blank_a: assert property (seq_active_q
        |=> digit_drive_out == 8'h00)
        else $error("display lit during sequential entry");

    shutdown_off_a: assert property (shut [*2]
        |-> digit_drive_out == 8'h00 && segment_out == 7'h00
        && !decimal_point_segment_out)
        else $error("drivers active while shut down");

    shutdown_hold_a: assert property (shut
        |=> $stable(slot_q) && $stable(time_q))
        else $error("scan moved while shut down");

    digit_gap_a: assert property ($past(digit_drive_out) != 8'h00
        && digit_drive_out != 8'h00
        |-> digit_drive_out == $past(digit_drive_out))
        else $error("digits changed without a blanking gap");

    capture_edge_a: assert property (commit
        |-> pin_q[9] && $past(pin_q[9]) == 1'b0
        && $past(pin_q[9], 2) == 1'b0)
        else $error("write committed without a stable strobe rise");

    ctrl_only_a: assert property (ctrl_wr
        |=> $stable(point_q) && $stable(decoded_q))
        else $error("control write changed display memory");

    // Single-digit entry must land at the address of the control word
    single_store_a: assert property (ram_we && !seq_active_q
        |=> point_q[$past(wr_addr)] == $past(hold_data_q[DB_POINT_BIT]))
        else $error("single-digit write missed its digit");

    digit_onehot_a: assert property (digit_drive_out != 8'h00
        |-> $onehot(digit_drive_out))
        else $error("more than one digit driven at once");

endmodule
`default_nettype wire

// ### tb/ldd_host_model.sv
/*
 * Host side of the decoder port: issues one write cycle at a time.
 * Assumes the caller waits for each write to finish before the next.
 */
`timescale 1ns/1ns
`default_nettype none
module ldd_host_model (
    input wire logic clk_in,
    output logic write_n_out,
    output logic reg_select_out,
    output logic [7:0] bus_out
);
    initial begin
        write_n_out = 1'b1;
        reg_select_out = 1'b0;
        bus_out = 8'h00;
    end

    // ------------------------------------------------------------
    // Write cycle: strobe low 6 cycles, bus held 1 more, then 8 idle cycles
    // ------------------------------------------------------------
    task automatic put(input logic sel, input logic [7:0] d);
        @(posedge clk_in);
        write_n_out <= 1'b0;
        reg_select_out <= sel;
        bus_out <= d;
        repeat (6) @(posedge clk_in);
        write_n_out <= 1'b1;
        @(posedge clk_in);
        // Released bus never keeps a stale copy of the last byte
        reg_select_out <= ~sel;
        bus_out <= ~d;
        repeat (8) @(posedge clk_in);
    endtask
endmodule
`default_nettype wire

// ### tb/led_digit_decoder_host_port_test.sv
/*
 * Self-checking bench for the LED decoder host port.
 * Assumes a small scan: 2 cycles per us, 16-cycle slot, 128-cycle frame.
 */
`timescale 1ns/1ns
`default_nettype none
module led_digit_decoder_host_port_test;
    import ldd_pkg::*;
    logic ref_clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic write_n;
    logic sel;
    logic [7:0] bus;
    logic [7:0] digit_drive;
    logic [6:0] segs;
    logic point;
    int error_cnt = 0;
    int samples_checked = 0;
    int ptr = 0;
    logic [7:0] cw = 8'h00;
    logic [3:0] nib [2][8];
    logic [7:0] rawb [8];
    logic dpb [8];
    logic dec [8];
    logic [6:0] hex_t [16];
    logic [6:0] bcd_t [16];
    int ord [8] = '{1, 4, 0, 6, 7, 5, 3, 2};

    always #5 ref_clk_in = ~ref_clk_in;

    ldd_host_model host (
        .clk_in(ref_clk_in),
        .write_n_out(write_n),
        .reg_select_out(sel),
        .bus_out(bus)
    );

    ldd_host_port #(.DIGIT_PERIOD_US(8), .BLANK_US(2), .CYC_PER_US(2)) uut (
        .ref_clk_in(ref_clk_in),
        .rst_in(rst_in),
        .write_n_in(write_n),
        .reg_select_in(sel),
        .host_write_bus_in(bus),
        .digit_drive_out(digit_drive),
        .segment_out(segs),
        .decimal_point_segment_out(point)
    );

    // ------------------------------------------------------------
    // Reference model and helpers
    // ------------------------------------------------------------
    task automatic check(input string what, input logic [7:0] e,
                         input logic [7:0] g);
        samples_checked++;
        if (g !== e) begin
            error_cnt++;
            $display("unexpected %s: expected %h, seen %h", what, e, g);
        end
    endtask

    task automatic store(input int i, input logic [7:0] d);
        rawb[i] = d;
        dpb[i] = d[7];
        dec[i] = cw[5];
        nib[cw[5] ? cw[3] : 1'b0][i] = d[3:0];
    endtask

    task automatic wr(input logic s, input logic [7:0] d);
        host.put(s, d);
        if (s) begin
            cw = d;
            ptr = 0;
        end else if (!cw[7]) begin
            store(int'(cw[2:0]), d);
        end else if (ptr < 8) begin
            store(ptr, d);
            ptr++;
        end
    endtask

    function automatic logic [7:0] expv(input int i);
        logic [7:0] r;
        r = rawb[i];
        if (dec[i]) begin
            r[6:0] = cw[6] ? hex_t[nib[cw[3]][i]] : bcd_t[nib[cw[3]][i]];
            return {~dpb[i], r[6:0]};
        end
        return {~r[7], r[6], r[5], r[4], r[0], r[3], r[1], r[2]};
    endfunction

    // Watch two frames: order, gaps, one-hot and each digit's pattern
    task automatic frame();
        logic [7:0] cap [8];
        logic seen [8];
        logic [7:0] prev;
        logic drk;
        int k;
        int lp;
        drk = !cw[4] || (cw[7] && ptr < 8);
        prev = 8'h00;
        lp = -1;
        k = 0;
        for (int i = 0; i < 8; i++) begin
            seen[i] = 1'b0;
        end
        repeat (300) begin
            @(negedge ref_clk_in);
            if (digit_drive === 8'h00) begin
                if ({point, segs} !== 8'h00) begin
                    check("gap segments", 8'h00, {point, segs});
                end
            end else begin
                k = $countones(digit_drive);
                check("digits on", 8'd1, 8'(k));
                for (int j = 0; j < 8; j++) begin
                    if (digit_drive[j]) begin
                        k = j;
                    end
                end
                if (digit_drive !== prev) begin
                    check("gap before digit", 8'h00, prev);
                    if (lp >= 0) begin
                        lp = ord[(lp + 1) % 8];
                        check("scan order", 8'(lp), 8'(k));
                    end
                    for (int j = 0; j < 8; j++) begin
                        if (ord[j] == k) begin
                            lp = j;
                        end
                    end
                end
                cap[k] = {point, segs};
                seen[k] = 1'b1;
            end
            prev = digit_drive;
        end
        for (int i = 0; i < 8; i++) begin
            check("digit seen", {7'h00, !drk}, {7'h00, seen[i]});
            if (!drk) begin
                check("digit pattern", expv(i), cap[i]);
            end
        end
    endtask

    task automatic close_out();
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_raw_seq();
        wr(1'b1, 8'h90);
        for (int i = 0; i < 3; i++) wr(1'b0, 8'(i * 37 + 5));
        frame();
        for (int i = 3; i < 8; i++) wr(1'b0, 8'(i * 37 + 5));
        frame();
        wr(1'b0, 8'h7f);
        frame();
    endtask

    task automatic t_banks();
        wr(1'b1, 8'hf0);
        for (int i = 0; i < 8; i++) begin
            wr(1'b0, 8'(i) | (i[0] ? 8'h80 : 8'h00));
        end
        wr(1'b1, 8'hf8);
        for (int i = 0; i < 8; i++) begin
            wr(1'b0, 8'(i + 8) | (i[1] ? 8'h80 : 8'h00));
        end
        frame();
        wr(1'b1, 8'h70);
        frame();
        wr(1'b1, 8'h38);
        frame();
    endtask

    task automatic t_single();
        wr(1'b1, 8'h77);
        wr(1'b0, 8'h8a);
        wr(1'b1, 8'h12);
        wr(1'b0, 8'h49);
        wr(1'b1, 8'h70);
        wr(1'b0, 8'h03);
        wr(1'b0, 8'h0c);
        frame();
        wr(1'b1, 8'h30);
        frame();
    endtask

    task automatic t_shutdown();
        wr(1'b1, 8'h61);
        frame();
        wr(1'b0, 8'h05);
        wr(1'b1, 8'h70);
        frame();
    endtask

    task automatic t_blank();
        wr(1'b1, 8'hb0);
        for (int i = 0; i < 3; i++) wr(1'b0, 8'h01);
        wr(1'b1, 8'hb0);
        for (int i = 0; i < 8; i++) wr(1'b0, 8'hff);
        frame();
        wr(1'b1, 8'h90);
        for (int i = 0; i < 8; i++) wr(1'b0, 8'h80);
        frame();
    endtask

    initial begin
        hex_t = '{7'h7e, 7'h30, 7'h6d, 7'h79, 7'h33, 7'h5b, 7'h5f, 7'h70,
                  7'h7f, 7'h7b, 7'h77, 7'h1f, 7'h4e, 7'h3d, 7'h4f, 7'h47};
        bcd_t = '{7'h7e, 7'h30, 7'h6d, 7'h79, 7'h33, 7'h5b, 7'h5f, 7'h70,
                  7'h7f, 7'h7b, 7'h01, 7'h4f, 7'h37, 7'h0e, 7'h67, 7'h00};
        for (int i = 0; i < 8; i++) begin
            nib[0][i] = 4'h0;
            nib[1][i] = 4'h0;
            rawb[i] = 8'h80;
            dpb[i] = 1'b1;
            dec[i] = 1'b0;
        end
        repeat (16) @(posedge ref_clk_in);
        rst_in <= 1'b0;
        frame();
        t_raw_seq();
        t_banks();
        t_single();
        t_shutdown();
        t_blank();
        close_out();
    end

    // A hang would stall far beyond the roughly 5000 cycles needed
    initial begin
        repeat (60000) @(posedge ref_clk_in);
        error_cnt++;
        close_out();
    end
endmodule
`default_nettype wire
